// file: hdl/i2c_cmd_pkg.sv
// Overview of operation
// R1: no transfer unless go bit set
// R2: idle write start go: start, send, transmit
// R3: idle write stop start go: start, send, stop
// R4: idle read nack start: receive nack, receive
// R5: idle read nack stop start: receive, stop
// R6: idle read ack start: receive ack, receive
// R7: transmit go: send next byte, stay
// R8: stop alone: stop, back to idle
// R9: transmit stop go: send, stop, idle
// R10: transmit write restart: send, stay transmit
// R11: write restart with stop: send, stop, idle
// R12: transmit read restart nack: enter receive
// R13: transmit read restart stop: send, stop, idle
// R14: transmit read restart ack: enter receive
// R15: receive go nack: receive byte, stay
// R16: receive stop go: last byte, stop, idle
// R17: receive ack go: receive, acknowledge, stay
// R18: receive read restart nack: stay receive
// R19: receive read restart stop: receive, stop, idle
// R20: receive read restart ack: stay receive
// R21: receive write restart: send, enter transmit
// R22: software stops receive only after nack
// R23: status invalid while busy; error on nack
// R24: unlisted or illegal commands do nothing
package i2c_cmd_pkg;
   localparam logic [7:0] ADDR_SLAVE = 8'h00;
   localparam logic [7:0] ADDR_CMD = 8'h04;
   localparam logic [7:0] ADDR_DATA = 8'h08;
   localparam logic [7:0] ADDR_TPR = 8'h0C;
   localparam int CMD_GO = 0;
   localparam int CMD_START = 1;
   localparam int CMD_STOP = 2;
   localparam int CMD_ACK = 3;
   localparam int ST_BUSY = 0;
   localparam int ST_ERROR = 1;
   localparam int ST_ADRNAK = 2;
   localparam int ST_DATNAK = 3;
   localparam int ST_ARBLST = 4;
   localparam int ST_IDLE = 5;
   localparam int ST_BUSBSY = 6;
   localparam logic [6:0] TPR_RESET = 7'h01;
   localparam logic [7:0] SCL_LP = 8'h06;
   localparam logic [7:0] SCL_HP = 8'h04;
   localparam logic [1:0] AXI_OKAY = 2'h0;
   localparam logic [1:0] AXI_SLVERR = 2'h2;
   typedef enum {M_IDLE, M_TX, M_RX} mstate_t;
   typedef enum {P_IDLE, P_START, P_ADDR, P_BYTE, P_STOP} phase_t;
   typedef struct packed {
      logic do_start;
      logic do_addr;
      logic do_byte;
      logic is_read;
      logic ack;
      logic do_stop;
      logic valid;
   } action_t;
endpackage : i2c_cmd_pkg

// file: hdl/i2c_master_command_decoder.sv
`timescale 1ns/100ps
module i2c_master_command_decoder (
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic [7:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic [7:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready,
   input wire logic scl_in,
   output logic scl_out,
   output logic scl_oe,
   input wire logic sda_in,
   output logic sda_out,
   output logic sda_oe
);
   // registers
   logic [7:0] target_address_register, next_tar;
   logic [7:0] tx_data, next_tx_data, rx_data, next_rx_data;
   logic [6:0] tpr, next_tpr;
   logic err, next_err, adrnak, next_adrnak, datnak, next_datnak;
   logic arblst, next_arblst, busbsy, next_busbsy;
   logic aw_held, next_aw_held, w_held, next_w_held;
   logic [7:0] aw_addr, next_aw_addr;
   logic [31:0] w_data, next_w_data;
   logic bvalid, next_bvalid, rvalid, next_rvalid;
   logic [1:0] bresp, next_bresp, rresp, next_rresp;
   logic [31:0] rdata, next_rdata;
   i2c_cmd_pkg::mstate_t mstate, next_mstate, after_state, next_after;
   i2c_cmd_pkg::phase_t phase, next_phase;
   i2c_cmd_pkg::action_t act, next_act, dec;
   logic [3:0] bitn, next_bitn;
   logic [1:0] quarter, next_quarter;
   logic [15:0] tick, next_tick;
   logic [8:0] shreg, next_shreg;
   logic scl_drv, next_scl_drv, sda_drv, next_sda_drv;
   logic [1:0] scl_sync, sda_sync;
   logic scl_s, sda_s, sda_q;
   logic wr_go, busy, cmd_wr;
   logic [15:0] tick_max;
   logic [3:0] cmd;

   assign scl_s = scl_sync[1];
   assign sda_s = sda_sync[1];
   assign busy = (phase != i2c_cmd_pkg::P_IDLE);
   // quarter of one bit time, scaled from the timer period field
   // tick counts 0..tick_max, so the quarter length less one
   assign tick_max = 16'(((({9'h000, tpr} + 16'h0001)
                    * ({8'h00, i2c_cmd_pkg::SCL_LP} + {8'h00,
                       i2c_cmd_pkg::SCL_HP})) >> 1) - 16'h0001);

   // AXI4-Lite slave; address and data taken in either order
   assign s_axi_awready = !aw_held && !bvalid;
   assign s_axi_wready = !w_held && !bvalid;
   assign s_axi_arready = !rvalid;
   assign s_axi_bvalid = bvalid;
   assign s_axi_bresp = bresp;
   assign s_axi_rvalid = rvalid;
   assign s_axi_rresp = rresp;
   assign s_axi_rdata = rdata;
   assign wr_go = aw_held && w_held && !bvalid;
   assign cmd_wr = wr_go && !busy &&
                   {aw_addr[7:2], 2'h0} == i2c_cmd_pkg::ADDR_CMD;
   assign cmd = w_data[3:0];

   // command table; a write while busy is refused as illegal
   always_comb begin
      logic rd;
      logic [2:0] sg;
      rd = target_address_register[0];
      sg = {cmd[i2c_cmd_pkg::CMD_STOP], cmd[i2c_cmd_pkg::CMD_START],
            cmd[i2c_cmd_pkg::CMD_GO]};
      dec = '0;
      next_after = mstate;
      dec.ack = cmd[i2c_cmd_pkg::CMD_ACK];
      dec.is_read = rd;
      dec.do_stop = cmd[i2c_cmd_pkg::CMD_STOP];
      case (mstate)
         i2c_cmd_pkg::M_IDLE: begin
            if (sg[1:0] == 2'h3 && !(rd && dec.ack && dec.do_stop)) begin
               // see R2 see R3 see R4 see R5 see R6
               dec.valid = 1'b1;
               dec.do_start = 1'b1;
               dec.do_addr = 1'b1;
               dec.do_byte = 1'b1;
               next_after = dec.do_stop ? i2c_cmd_pkg::M_IDLE
                          : (rd ? i2c_cmd_pkg::M_RX : i2c_cmd_pkg::M_TX);
            end
         end
         i2c_cmd_pkg::M_TX, i2c_cmd_pkg::M_RX: begin
            if (sg == 3'h4) begin
               dec.valid = 1'b1; // see R8
               next_after = i2c_cmd_pkg::M_IDLE;
            end else if (sg[1:0] == 2'h1 && !(mstate == i2c_cmd_pkg::M_RX
                         && dec.ack && dec.do_stop)) begin
               // see R7 see R9 see R15 see R16 see R17
               dec.valid = 1'b1;
               dec.do_byte = 1'b1;
               dec.is_read = (mstate == i2c_cmd_pkg::M_RX);
               next_after = dec.do_stop ? i2c_cmd_pkg::M_IDLE : mstate;
            end else if (sg[1:0] == 2'h3 && !(rd && dec.ack && dec.do_stop))
            begin
               // see R10 see R11 see R12 see R14 see R18 see R19 see R20
               // see R21
               dec.valid = 1'b1;
               dec.do_start = 1'b1;
               dec.do_addr = 1'b1;
               dec.do_byte = 1'b1;
               // transmit state with read and stop sends, as tabled
               if (mstate == i2c_cmd_pkg::M_TX && rd && dec.do_stop)
                  dec.is_read = 1'b0; // see R13
               next_after = dec.do_stop ? i2c_cmd_pkg::M_IDLE
                          : (rd ? i2c_cmd_pkg::M_RX : i2c_cmd_pkg::M_TX);
            end
         end
         default: dec = '0;
      endcase
      if (busy) begin
         dec = '0; // see R24
         next_after = mstate;
      end
      if (!cmd[i2c_cmd_pkg::CMD_GO])
         dec.do_byte = 1'b0; // see R1
   end

   always_comb begin
      next_aw_held = aw_held;
      next_aw_addr = aw_addr;
      next_w_held = w_held;
      next_w_data = w_data;
      next_bvalid = bvalid;
      next_bresp = bresp;
      next_rvalid = rvalid;
      next_rresp = rresp;
      next_rdata = rdata;
      next_tar = target_address_register;
      next_tx_data = tx_data;
      next_tpr = tpr;
      next_act = act;
      if (s_axi_awvalid && s_axi_awready) begin
         next_aw_held = 1'b1;
         next_aw_addr = s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
         next_w_held = 1'b1;
         next_w_data = s_axi_wdata;
      end
      if (wr_go) begin
         next_aw_held = 1'b0;
         next_w_held = 1'b0;
         next_bvalid = 1'b1;
         next_bresp = i2c_cmd_pkg::AXI_OKAY;
         case ({aw_addr[7:2], 2'h0})
            i2c_cmd_pkg::ADDR_SLAVE: next_tar = w_data[7:0];
            i2c_cmd_pkg::ADDR_DATA: if (!busy) next_tx_data = w_data[7:0];
            i2c_cmd_pkg::ADDR_TPR: next_tpr = w_data[6:0];
            // a refused command must not disturb the transfer under way
            i2c_cmd_pkg::ADDR_CMD: if (!busy) next_act = dec;
            default: next_bresp = i2c_cmd_pkg::AXI_SLVERR;
         endcase
      end
      if (bvalid && s_axi_bready)
         next_bvalid = 1'b0;
      if (s_axi_arvalid && s_axi_arready) begin
         next_rvalid = 1'b1;
         next_rresp = i2c_cmd_pkg::AXI_OKAY;
         next_rdata = '0;
         case ({s_axi_araddr[7:2], 2'h0})
            i2c_cmd_pkg::ADDR_SLAVE: next_rdata[7:0] = target_address_register;
            i2c_cmd_pkg::ADDR_DATA: next_rdata[7:0] = rx_data;
            i2c_cmd_pkg::ADDR_TPR: next_rdata[6:0] = tpr;
            i2c_cmd_pkg::ADDR_CMD: begin
               next_rdata[i2c_cmd_pkg::ST_BUSY] = busy;
               // error, nack and arbitration lost flags masked while busy, so they never look valid then
               next_rdata[i2c_cmd_pkg::ST_ERROR] = err && !busy; // see R23
               next_rdata[i2c_cmd_pkg::ST_ADRNAK] = adrnak && !busy;
               next_rdata[i2c_cmd_pkg::ST_DATNAK] = datnak && !busy;
               next_rdata[i2c_cmd_pkg::ST_ARBLST] = arblst && !busy;
               next_rdata[i2c_cmd_pkg::ST_IDLE] = !busy;
               next_rdata[i2c_cmd_pkg::ST_BUSBSY] = busbsy;
            end
            default: next_rresp = i2c_cmd_pkg::AXI_SLVERR;
         endcase
      end else if (rvalid && s_axi_rready)
         next_rvalid = 1'b0;
      if (phase == i2c_cmd_pkg::P_IDLE && act.valid)
         next_act.valid = 1'b0;
   end

   // bus engine: each bit is four quarters; scl low on 0,3, high on 1,2
   always_comb begin
      logic qend, last;
      qend = (tick == tick_max);
      last = qend && (quarter == 2'h3);
      next_tick = qend ? 16'h0000 : tick + 16'h0001;
      next_quarter = qend ? quarter + 2'h1 : quarter;
      next_phase = phase;
      next_bitn = bitn;
      next_shreg = shreg;
      next_scl_drv = scl_drv;
      next_sda_drv = sda_drv;
      next_err = err;
      next_adrnak = adrnak;
      next_datnak = datnak;
      next_arblst = arblst;
      next_rx_data = rx_data;
      next_mstate = mstate;
      // start and stop seen on the line
      next_busbsy = busbsy;
      if (scl_s && sda_q && !sda_s) next_busbsy = 1'b1;
      if (scl_s && !sda_q && sda_s) next_busbsy = 1'b0;
      case (phase)
         i2c_cmd_pkg::P_IDLE: begin
            next_tick = 16'h0000;
            next_quarter = 2'h0;
            if (act.valid) begin
               next_err = 1'b0;
               next_adrnak = 1'b0;
               next_datnak = 1'b0;
               next_arblst = 1'b0;
               next_phase = act.do_start ? i2c_cmd_pkg::P_START
                          : act.do_byte ? i2c_cmd_pkg::P_BYTE
                          : i2c_cmd_pkg::P_STOP;
               next_bitn = 4'h0;
               next_shreg = act.do_start ? {target_address_register, 1'b1}
                          : act.is_read ? {8'hFF, ~act.ack}
                          : {tx_data, 1'b1};
            end
         end
         i2c_cmd_pkg::P_START: begin
            // q0 release sda, q1 scl high, q2 sda low, scl low at the end of q3
            next_sda_drv = (quarter >= 2'h2) || (quarter == 2'h0 && 1'b0);
            next_scl_drv = (quarter == 2'h0 && scl_drv) || last;
            if (last) begin
               next_phase = i2c_cmd_pkg::P_ADDR;
               next_bitn = 4'h0;
            end
         end
         i2c_cmd_pkg::P_ADDR, i2c_cmd_pkg::P_BYTE: begin
            next_sda_drv = !shreg[8];
            next_scl_drv = (quarter == 2'h0) || (quarter == 2'h3);
            if (qend && quarter == 2'h1) begin
               if (bitn == 4'h8) begin
                  if (phase == i2c_cmd_pkg::P_ADDR && sda_s) begin
                     next_adrnak = 1'b1; // see R23
                     next_err = 1'b1;
                  end
                  if (phase == i2c_cmd_pkg::P_BYTE && !act.is_read && sda_s)
                  begin
                     next_datnak = 1'b1;
                     next_err = 1'b1;
                  end
               end else if (shreg[8] && !sda_s &&
                            !(phase == i2c_cmd_pkg::P_BYTE && act.is_read))
                  next_arblst = 1'b1;
               if (phase == i2c_cmd_pkg::P_BYTE && act.is_read && bitn < 4'h8)
                  next_rx_data = {rx_data[6:0], sda_s};
            end
            if (last) begin
               next_shreg = {shreg[7:0], 1'b1};
               next_bitn = bitn + 4'h1;
               if (bitn == 4'h8) begin
                  next_bitn = 4'h0;
                  next_shreg = act.is_read ? {8'hFF, ~act.ack}
                             : {tx_data, 1'b1};
                  if (phase == i2c_cmd_pkg::P_ADDR && !adrnak && act.do_byte)
                     next_phase = i2c_cmd_pkg::P_BYTE;
                  else
                     next_phase = (act.do_stop || adrnak) ?
                        i2c_cmd_pkg::P_STOP : i2c_cmd_pkg::P_IDLE;
                  if (next_phase == i2c_cmd_pkg::P_IDLE)
                     next_mstate = adrnak ? mstate : after_state;
               end
            end
         end
         i2c_cmd_pkg::P_STOP: begin
            // q0 sda low, q1 scl high, q2 sda release
            next_sda_drv = (quarter <= 2'h1);
            next_scl_drv = (quarter == 2'h0);
            if (last) begin
               next_phase = i2c_cmd_pkg::P_IDLE;
               next_mstate = i2c_cmd_pkg::M_IDLE;
            end
         end
         default: next_phase = i2c_cmd_pkg::P_IDLE;
      endcase
   end

   always_ff @(posedge aclk) begin
      scl_sync <= {scl_sync[0], scl_in};
      sda_sync <= {sda_sync[0], sda_in};
      if (!aresetn) begin
         aw_held <= 1'b0;
         aw_addr <= '0;
         w_held <= 1'b0;
         w_data <= '0;
         bvalid <= 1'b0;
         bresp <= i2c_cmd_pkg::AXI_OKAY;
         rvalid <= 1'b0;
         rresp <= i2c_cmd_pkg::AXI_OKAY;
         rdata <= '0;
         target_address_register <= '0;
         tx_data <= '0;
         rx_data <= '0;
         tpr <= i2c_cmd_pkg::TPR_RESET;
         act <= '0;
         after_state <= i2c_cmd_pkg::M_IDLE;
         mstate <= i2c_cmd_pkg::M_IDLE;
         phase <= i2c_cmd_pkg::P_IDLE;
         bitn <= '0;
         quarter <= '0;
         tick <= '0;
         shreg <= '1;
         scl_drv <= 1'b0;
         sda_drv <= 1'b0;
         err <= 1'b0;
         adrnak <= 1'b0;
         datnak <= 1'b0;
         arblst <= 1'b0;
         busbsy <= 1'b0;
         sda_q <= 1'b1;
      end else begin
         aw_held <= next_aw_held;
         aw_addr <= next_aw_addr;
         w_held <= next_w_held;
         w_data <= next_w_data;
         bvalid <= next_bvalid;
         bresp <= next_bresp;
         rvalid <= next_rvalid;
         rresp <= next_rresp;
         rdata <= next_rdata;
         target_address_register <= next_tar;
         tx_data <= next_tx_data;
         rx_data <= next_rx_data;
         tpr <= next_tpr;
         act <= next_act;
         if (wr_go && {aw_addr[7:2], 2'h0} == i2c_cmd_pkg::ADDR_CMD && !busy)
            after_state <= next_after;
         mstate <= next_mstate;
         phase <= next_phase;
         bitn <= next_bitn;
         quarter <= next_quarter;
         tick <= next_tick;
         shreg <= next_shreg;
         scl_drv <= next_scl_drv;
         sda_drv <= next_sda_drv;
         err <= next_err;
         adrnak <= next_adrnak;
         datnak <= next_datnak;
         arblst <= next_arblst;
         busbsy <= next_busbsy;
         sda_q <= sda_s;
      end
   end

   // open drain: only ever pull low
   assign scl_out = 1'b0;
   assign sda_out = 1'b0;
   assign scl_oe = scl_drv;
   assign sda_oe = sda_drv;

   no_go_a: assert property (@(posedge aclk) disable iff (!aresetn) // see R1
      (cmd_wr && !cmd[0]) |=> !act.do_byte)
      else $error("byte launched without go");
   stop_only_a: assert property (@(posedge aclk) // see R8
      disable iff (!aresetn)
      (phase == i2c_cmd_pkg::P_STOP && next_phase == i2c_cmd_pkg::P_IDLE)
      |=> mstate == i2c_cmd_pkg::M_IDLE)
      else $error("stop did not return to idle");
   busy_hide_a: assert property (@(posedge aclk) // see R23
      disable iff (!aresetn)
      (s_axi_arvalid && s_axi_arready && busy &&
       {s_axi_araddr[7:2], 2'h0} == i2c_cmd_pkg::ADDR_CMD) |=> !rdata[1])
      else $error("error flag visible while busy");
   illegal_nop_a: assert property (@(posedge aclk) // see R24
      disable iff (!aresetn)
      (cmd_wr && cmd == 4'hF && target_address_register[0]) |=> !act.valid)
      else $error("illegal command acted on");
   idle_tx_a: assert property (@(posedge aclk) disable iff (!aresetn) // see R2
      (cmd_wr && mstate == i2c_cmd_pkg::M_IDLE &&
       !target_address_register[0] && cmd[2:0] == 3'h3) |=>
      (act.valid && act.do_start && !act.is_read &&
       after_state == i2c_cmd_pkg::M_TX))
      else $error("idle start send decoded wrong");
   tx_go_a: assert property (@(posedge aclk) disable iff (!aresetn) // see R7
      (cmd_wr && mstate == i2c_cmd_pkg::M_TX && cmd[2:0] == 3'h1) |=>
      (act.valid && act.do_byte && !act.do_start && !act.is_read &&
       after_state == i2c_cmd_pkg::M_TX))
      else $error("transmit send decoded wrong");
   cv_write_c: cover property (@(posedge aclk) phase == i2c_cmd_pkg::P_BYTE
      && !act.is_read);
   cv_read_c: cover property (@(posedge aclk) phase == i2c_cmd_pkg::P_BYTE
      && act.is_read);
   cv_stop_c: cover property (@(posedge aclk) phase == i2c_cmd_pkg::P_STOP);
endmodule : i2c_master_command_decoder

// file: testbench/i2c_master_command_decoder_tb_top.sv
`timescale 1ns/100ps
module i2c_master_command_decoder_tb_top;
   localparam logic [7:0] WR = 8'h54;
   localparam logic [7:0] RD = 8'h55;
   localparam logic [7:0] NONE = 8'h20;
   localparam logic [7:0] BASE = 8'hC3;
   localparam int LIMIT = 90000;
   logic aclk, aresetn, s_axi_awvalid, s_axi_awready, s_axi_wvalid;
   logic s_axi_wready, s_axi_bvalid, s_axi_bready, s_axi_arvalid;
   logic s_axi_arready, s_axi_rvalid, s_axi_rready;
   logic [7:0] s_axi_awaddr, s_axi_araddr, last_rx;
   logic [31:0] s_axi_wdata, s_axi_rdata;
   logic [3:0] s_axi_wstrb;
   logic [1:0] s_axi_bresp, s_axi_rresp;
   logic scl_out, scl_oe, sda_out, sda_oe, sda_pull, mute;
   int starts, stops, bad_count, samples_checked, cycles;
   // open-drain lines: any party pulling wins, otherwise pull-up
   wire logic scl = ~scl_oe;
   wire logic sda = ~(sda_oe | sda_pull);
   i2c_master_command_decoder u_i2c_master_command_decoder (
      .aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
      .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready,
      .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
      .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
      .s_axi_rvalid, .s_axi_rready, .scl_in(scl), .scl_out, .scl_oe,
      .sda_in(sda), .sda_out, .sda_oe);
   i2c_slave_model #(.ADDR(7'h2A), .TX_BASE(BASE)) u_i2c_slave_model (
      .scl(scl), .sda(sda), .mute(mute), .sda_pull(sda_pull),
      .last_rx(last_rx), .starts(starts), .stops(stops));
   initial begin
      aclk = 1'b0;
      forever #10 aclk = ~aclk;
   end
   task automatic close_out();
      $display("checks %0d mismatches %0d", samples_checked, bad_count);
      if (bad_count == 0 && samples_checked > 0)
         $display("All tests passed");
      else
         $display("Some tests failed");
      $finish;
   endtask : close_out
   always @(posedge aclk) begin
      cycles <= cycles + 1;
      if (cycles == LIMIT) begin
         bad_count++;
         close_out();
      end
   end
   task automatic check(input string nm, input logic [31:0] seen,
                        input logic [31:0] exp);
      samples_checked++;
      if (seen !== exp) begin
         bad_count++;
         $display("[ERR] %s expected %h seen %h", nm, exp, seen);
      end
   endtask : check
   task automatic axi_wr(input logic [7:0] a, input logic [31:0] d,
                         output logic [1:0] resp);
      logic ap;
      logic wp;
      @(posedge aclk);
      s_axi_awaddr <= a;
      s_axi_awvalid <= 1'b1;
      s_axi_wdata <= d;
      s_axi_wvalid <= 1'b1;
      s_axi_bready <= 1'b1;
      ap = 1'b1;
      wp = 1'b1;
      forever begin
         @(posedge aclk);
         if (s_axi_bvalid === 1'b1) begin
            resp = s_axi_bresp;
            s_axi_bready <= 1'b0;
            break;
         end
         if (ap && s_axi_awready === 1'b1) begin
            ap = 1'b0;
            s_axi_awvalid <= 1'b0;
         end
         if (wp && s_axi_wready === 1'b1) begin
            wp = 1'b0;
            s_axi_wvalid <= 1'b0;
         end
      end
   endtask : axi_wr
   task automatic axi_rd(input logic [7:0] a, output logic [31:0] d,
                         output logic [1:0] resp);
      @(posedge aclk);
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'b1;
      s_axi_rready <= 1'b1;
      forever begin
         @(posedge aclk);
         if (s_axi_arready === 1'b1) s_axi_arvalid <= 1'b0;
         if (s_axi_rvalid === 1'b1) begin
            d = s_axi_rdata;
            resp = s_axi_rresp;
            s_axi_rready <= 1'b0;
            break;
         end
      end
   endtask : axi_rd
   task automatic wait_idle(output logic [31:0] st);
      logic [1:0] r;
      do begin
         axi_rd(i2c_cmd_pkg::ADDR_CMD, st, r);
         if (st[0] === 1'b1) check("err_busy", {29'h0, st[3:1]}, 32'h0);
      end while (st[0] !== 1'b0);
   endtask : wait_idle
   // kind 1 compares the slave's last byte, kind 2 the data register
   task automatic step(input logic [7:0] sa, input logic [7:0] wd,
                       input logic [3:0] cmd, input int ds, input int dp,
                       input int bb, input logic [2:0] er, input int kind,
                       input logic [7:0] ev);
      int s0;
      int p0;
      logic [31:0] st;
      logic [31:0] d;
      logic [1:0] r;
      s0 = starts;
      p0 = stops;
      axi_wr(i2c_cmd_pkg::ADDR_SLAVE, {24'h0, sa}, r);
      axi_wr(i2c_cmd_pkg::ADDR_DATA, {24'h0, wd}, r);
      axi_wr(i2c_cmd_pkg::ADDR_CMD, {28'h0, cmd}, r);
      check("cmd_resp", {30'h0, r}, {30'h0, i2c_cmd_pkg::AXI_OKAY});
      wait_idle(st);
      check("starts", 32'(starts - s0), 32'(ds));
      check("stops", 32'(stops - p0), 32'(dp));
      check("bus_busy", {31'h0, st[6]}, 32'(bb));
      check("errors", {29'h0, st[3:1]}, {29'h0, er});
      if (kind == 1) check("slave_rx", {24'h0, last_rx}, {24'h0, ev});
      if (kind == 2) begin
         axi_rd(i2c_cmd_pkg::ADDR_DATA, d, r);
         check("rx_data", d, {24'h0, ev});
      end
   endtask : step
   initial begin
      logic [31:0] d;
      logic [1:0] r;
      {s_axi_awvalid, s_axi_wvalid, s_axi_bready} = 3'h0;
      {s_axi_arvalid, s_axi_rready, mute} = 3'h0;
      s_axi_awaddr = 8'h00;
      s_axi_araddr = 8'h00;
      s_axi_wdata = 32'h0;
      s_axi_wstrb = 4'hF;
      aresetn = 1'b0;
      bad_count = 0;
      samples_checked = 0;
      cycles = 0;
      repeat (20) @(posedge aclk);
      aresetn <= 1'b1;
      axi_rd(i2c_cmd_pkg::ADDR_TPR, d, r);
      check("tpr_reset", d, {25'h0, i2c_cmd_pkg::TPR_RESET});
      axi_rd(8'h10, d, r);
      check("rd_unmapped", {30'h0, r}, {30'h0, i2c_cmd_pkg::AXI_SLVERR});
      axi_wr(8'h10, 32'h0, r);
      check("wr_unmapped", {30'h0, r}, {30'h0, i2c_cmd_pkg::AXI_SLVERR});
      axi_wr(i2c_cmd_pkg::ADDR_TPR, 32'h2, r);
      axi_rd(i2c_cmd_pkg::ADDR_TPR, d, r);
      check("tpr_rw", d, 32'h2);
      axi_wr(i2c_cmd_pkg::ADDR_TPR, {25'h0, i2c_cmd_pkg::TPR_RESET}, r);
      step(WR, 8'h00, 4'h6, 0, 0, 0, 3'h0, 0, 8'h00);
      step(WR, 8'h3C, 4'h7, 1, 1, 0, 3'h0, 1, 8'h3C);
      step(WR, 8'h11, 4'h3, 1, 0, 1, 3'h0, 1, 8'h11);
      step(WR, 8'h22, 4'h9, 0, 0, 1, 3'h0, 1, 8'h22);
      step(WR, 8'h33, 4'h3, 1, 0, 1, 3'h0, 1, 8'h33);
      step(RD, 8'h00, 4'hF, 0, 0, 1, 3'h0, 1, 8'h33);
      step(RD, 8'h00, 4'h3, 1, 0, 1, 3'h0, 2, BASE);
      step(RD, 8'h00, 4'hD, 0, 0, 1, 3'h0, 0, 8'h00);
      step(RD, 8'h00, 4'h3, 1, 0, 1, 3'h0, 2, BASE);
      step(RD, 8'h00, 4'hB, 1, 0, 1, 3'h0, 2, BASE);
      step(RD, 8'h00, 4'h9, 0, 0, 1, 3'h0, 2, BASE + 8'h01);
      step(RD, 8'h00, 4'h1, 0, 0, 1, 3'h0, 2, BASE + 8'h02);
      step(RD, 8'h00, 4'h4, 0, 1, 0, 3'h0, 0, 8'h00);
      step(RD, 8'h00, 4'hB, 1, 0, 1, 3'h0, 2, BASE);
      step(RD, 8'h00, 4'h5, 0, 1, 0, 3'h0, 2, BASE + 8'h01);
      step(RD, 8'h00, 4'h3, 1, 0, 1, 3'h0, 2, BASE);
      step(WR, 8'h44, 4'h3, 1, 0, 1, 3'h0, 1, 8'h44);
      step(WR, 8'h55, 4'h5, 0, 1, 0, 3'h0, 1, 8'h55);
      step(RD, 8'h00, 4'h7, 1, 1, 0, 3'h0, 2, BASE);
      step(WR, 8'h66, 4'h3, 1, 0, 1, 3'h0, 1, 8'h66);
      step(WR, 8'h00, 4'h4, 0, 1, 0, 3'h0, 0, 8'h00);
      step(WR, 8'h68, 4'h3, 1, 0, 1, 3'h0, 1, 8'h68);
      step(WR, 8'h77, 4'h7, 1, 1, 0, 3'h0, 1, 8'h77);
      step(RD, 8'h00, 4'h3, 1, 0, 1, 3'h0, 2, BASE);
      step(WR, 8'h5A, 4'h7, 1, 1, 0, 3'h0, 1, 8'h5A);
      step(RD, 8'h00, 4'h3, 1, 0, 1, 3'h0, 2, BASE);
      step(RD, 8'h00, 4'h7, 1, 1, 0, 3'h0, 2, BASE);
      step(WR, 8'h12, 4'h3, 1, 0, 1, 3'h0, 1, 8'h12);
      // a muted slave leaves every data byte unacknowledged
      mute <= 1'b1;
      step(RD, 8'h00, 4'h7, 1, 1, 0, 3'h5, 0, 8'h00);
      step(WR, 8'h34, 4'h7, 1, 1, 0, 3'h5, 0, 8'h00);
      mute <= 1'b0;
      step(NONE, 8'h00, 4'h7, 1, 1, 0, 3'h3, 0, 8'h00);
      close_out();
   end
endmodule : i2c_master_command_decoder_tb_top

// file: testbench/i2c_slave_model.sv
`timescale 1ns/100ps
module i2c_slave_model #(
   parameter logic [6:0] ADDR = 7'h2A,
   parameter logic [7:0] TX_BASE = 8'hC3
) (
   input wire logic scl,
   input wire logic sda,
   input wire logic mute,
   output logic sda_pull,
   output logic [7:0] last_rx,
   output int starts,
   output int stops
);
   logic [3:0] bit_n;
   logic act, adr_ph, sel, rd;
   logic [7:0] sh, txd;
   initial begin
      sda_pull = 1'b0;
      starts = 0;
      stops = 0;
      act = 1'b0;
      sel = 1'b0;
      last_rx = 8'h00;
   end
   // start and repeated start both restart the byte framing
   always @(negedge sda) begin
      if (scl === 1'b1) begin
         starts++;
         act = 1'b1;
         adr_ph = 1'b1;
         sel = 1'b0;
         bit_n = 4'h0;
         sda_pull = 1'b0;
      end
   end
   always @(posedge sda) begin
      if (scl === 1'b1) begin
         stops++;
         act = 1'b0;
         sel = 1'b0;
      end
   end
   always @(posedge scl) begin
      if (act) begin
         if (bit_n < 4'h8) begin
            sh = {sh[6:0], sda};
            bit_n++;
         end else begin
            bit_n = 4'h0;
            // the address ack clock is no data byte: no advance there
            if (adr_ph) adr_ph = 1'b0;
            else if (sel && rd) begin
               txd++;
               // a master nack ends our read data, line left to the stop
               if (sda) sel = 1'b0;
            end
         end
      end
   end
   // lines only change while scl is low; released sda floats to pull-up
   always @(negedge scl) begin
      if (act) begin
         sda_pull = 1'b0;
         if (bit_n == 4'h8 && adr_ph) begin
            sel = (sh[7:1] == ADDR);
            rd = sh[0];
            txd = TX_BASE;
            sda_pull = sel;
            act = sel;
         end else if (sel && rd) begin
            if (bit_n < 4'h8) sda_pull = !mute && !txd[7 - bit_n];
         end else if (bit_n == 4'h8) begin
            last_rx = sh;
            sda_pull = !mute;
         end
      end
   end
endmodule : i2c_slave_model
